// [verilog/lco_pkg.sv]
// Package: command codes, policy bits, strap table and timing constants
package lco_pkg;

  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CAL_INTERVAL_MS = 800;
  localparam int unsigned CAL_INTERVAL_CYC = CLK_HZ / 1000 * CAL_INTERVAL_MS;
  localparam int unsigned IVL_W = 25;

  // Command codes on the link, also the host register offsets
  localparam logic [3:0] CMD_OPERATION = 4'h0;
  localparam logic [3:0] CMD_ONOFF_CFG = 4'h1;
  localparam logic [3:0] CMD_MODEL = 4'h2;
  localparam logic [3:0] CMD_POLICY = 4'h3;
  localparam logic [3:0] CMD_GAIN = 4'h4;
  localparam logic [3:0] CMD_DAMPING = 4'h5;
  localparam logic [3:0] CMD_LOOP_CFG = 4'h6;
  localparam logic [3:0] CMD_FSW = 4'h7;
  localparam logic [3:0] CMD_STATUS = 4'h8;
  localparam logic [3:0] CMD_SETPOINT = 4'h9;
  localparam logic [3:0] HOST_SWITCH = 4'hF;

  // Field positions
  localparam int OP_ON_BIT = 7;
  localparam int ONOFF_POS_BIT = 0;
  localparam int ONOFF_PIN_BIT = 1;
  localparam int ONOFF_CMD_BIT = 2;
  localparam int POL_STORE_BIT = 2;
  localparam int POL_CONT_BIT = 8;
  localparam int POL_RAMP_BIT = 9;
  localparam int POL_FIRST_BIT = 12;
  localparam int LOOP_NEG_BIT = 0;
  localparam int FLC_DIV_SHIFT = 5;

  // Reset values
  localparam logic [15:0] POLICY_RST = 16'h024B;
  localparam logic [15:0] ONOFF_RST = 16'h0003;
  localparam logic [15:0] GAIN_RST = 16'h0080;
  localparam logic [15:0] DAMP_RST = 16'h0180;
  localparam logic [15:0] FSW_RST = 16'h0258;
  localparam logic [15:0] MODEL_RST = FSW_RST >> FLC_DIV_SHIFT;

  // Strap thresholds in 10 ohm units and setpoints in mV
  localparam logic [12:0] STRAP_TRACK_MAX = 13'h1A6;
  localparam logic [12:0] STRAP_OHM10 [16] = '{
    13'h1FF, 13'h26B, 13'h2CB, 13'h339, 13'h3B9, 13'h44C, 13'h4F6, 13'h5BE,
    13'h6F4, 13'h866, 13'hA32, 13'hC58, 13'hEF6, 13'h1144, 13'h13F6,
    13'h170C};
  localparam logic [12:0] STRAP_MV [16] = '{
    13'h258, 13'h2BC, 13'h2EE, 13'h320, 13'h352, 13'h384, 13'h3B6, 13'h3E8,
    13'h41A, 13'h44C, 13'h4B0, 13'h5DC, 13'h708, 13'h9C4, 13'hCE4, 13'h1388};

  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_RAMP = 2'b01,
    ST_CAL = 2'b10,
    ST_RUN = 2'b11
  } lco_state_type;
endpackage : lco_pkg

// [verilog/lco_link_if.sv]
// Interface: command link, remote on/off pin and output good pin
`timescale 1ns/1ps
interface lco_link_if;
  logic cmd_wr;
  logic cmd_rd;
  logic [3:0] cmd_code;
  logic [15:0] cmd_wdata;
  logic [15:0] cmd_rdata;
  logic ctrl_out;
  logic ctrl_oe;
  logic ctrl_level;
  logic good_out;
  logic good_oe;
  logic good_level;
  logic out_en;

  // Both pins are open drain with a pull-up
  assign ctrl_level = ctrl_oe ? ctrl_out : 1'b1;
  assign good_level = good_oe ? good_out : 1'b1;

  modport dev (
    input cmd_wr, cmd_rd, cmd_code, cmd_wdata, ctrl_level,
    output cmd_rdata, good_out, good_oe, out_en
  );
  modport host (
    output cmd_wr, cmd_rd, cmd_code, cmd_wdata, ctrl_out, ctrl_oe,
    input cmd_rdata, good_level, out_en
  );
endinterface : lco_link_if

// [verilog/lco_strap.sv]
// Voltage-select strap capture and setpoint decode
`timescale 1ns/1ps
module lco_strap
  import lco_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Measured strap
  input wire logic [12:0] strap_code_i,
  input wire logic strap_open_i,
  // Decoded result
  output logic [12:0] setpoint_mv_o,
  output logic [12:0] vmax_mv_o,
  output logic [3:0] index_o,
  output logic track_o,
  output logic open_o
);
  logic done_reg;
  logic [3:0] idx_next;

  always_comb
  begin
    idx_next = 4'h0;
    for (int i = 1; i < 16; i++)
      if (strap_code_i >= STRAP_OHM10[i])
        idx_next = 4'(i);
  end

  // Sampled once after power-up reset, then frozen
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
    begin
      done_reg <= 1'b0;
      index_o <= 4'h0;
      open_o <= 1'b0;
      track_o <= 1'b0;
      setpoint_mv_o <= 13'h0;
      vmax_mv_o <= 13'h0;
    end
    else if (!done_reg)
    begin
      done_reg <= 1'b1;
      index_o <= idx_next;
      open_o <= strap_open_i;
      track_o <= !strap_open_i && strap_code_i <= STRAP_TRACK_MAX;
      vmax_mv_o <= STRAP_MV[idx_next];
      if (strap_open_i || strap_code_i <= STRAP_TRACK_MAX)
        setpoint_mv_o <= 13'h0;
      else
        setpoint_mv_o <= STRAP_MV[idx_next];
    end
endmodule : lco_strap

// [verilog/lco_device.sv]
// Converter control end: enable, calibration sequencing, model word
`timescale 1ns/1ps
module lco_device
  import lco_pkg::*;
#(
  parameter int unsigned CAL_IVL_CYC = CAL_INTERVAL_CYC
)
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Link to host
  lco_link_if.dev link,
  // Strap and NVM
  input wire logic [12:0] strap_code_i,
  input wire logic strap_open_i,
  input wire logic [15:0] nvm_freq_i,
  // Power stage status
  input wire logic ramp_done_i,
  input wire logic out_above_90_i,
  input wire logic meas_done_i,
  input wire logic [15:0] meas_freq_i,
  // Control outputs
  output logic output_enable_o,
  output logic low_bw_o,
  output logic inject_o,
  output logic store_all_o,
  output logic [15:0] output_resonance_freq_o,
  output logic [15:0] fsw_o,
  output logic [15:0] loop_gain_o,
  output logic [15:0] damping_ratio_setting_o,
  output logic neg_duty_o,
  output logic [12:0] setpoint_mv_o,
  output logic [12:0] vmax_mv_o,
  output logic track_o
);
  if (CAL_IVL_CYC < 1 || CAL_IVL_CYC > (1 << IVL_W))
  begin : g_bad_ivl
    $error("CAL_IVL_CYC does not fit the interval counter");
  end

  lco_state_type state_reg;
  lco_state_type state_next;
  logic [15:0] onoff_reg;
  logic op_on_reg;
  logic [15:0] policy_reg;
  logic [15:0] loop_cfg_reg;
  logic first_done_reg;
  logic cal_ok_reg;
  logic ctrl_meta_reg;
  logic ctrl_sync_reg;
  logic [IVL_W-1:0] ivl_cnt_reg;
  logic [15:0] rdata_reg;
  logic [3:0] strap_idx;
  logic strap_open;
  logic pin_on;
  logic enable;
  logic cal_after_ramp;
  logic wr_model;

  lco_strap lco_strap_i (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .strap_code_i(strap_code_i),
    .strap_open_i(strap_open_i),
    .setpoint_mv_o(setpoint_mv_o),
    .vmax_mv_o(vmax_mv_o),
    .index_o(strap_idx),
    .track_o(track_o),
    .open_o(strap_open)
  );

  // Remote on/off pin synchroniser
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
    begin
      ctrl_meta_reg <= 1'b0;
      ctrl_sync_reg <= 1'b0;
    end
    else
    begin
      ctrl_meta_reg <= link.ctrl_level;
      ctrl_sync_reg <= ctrl_meta_reg;
    end

  assign pin_on = onoff_reg[ONOFF_POS_BIT] ? ctrl_sync_reg
                                           : !ctrl_sync_reg;
  assign enable = (!onoff_reg[ONOFF_PIN_BIT] || pin_on)
               && (!onoff_reg[ONOFF_CMD_BIT] || op_on_reg);
  assign cal_after_ramp = policy_reg[POL_CONT_BIT]
    || (policy_reg[POL_RAMP_BIT]
        && !(policy_reg[POL_FIRST_BIT] && first_done_reg));
  assign wr_model = link.cmd_wr && link.cmd_code == CMD_MODEL;

  // Configuration written by the host
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
    begin
      onoff_reg <= ONOFF_RST;
      op_on_reg <= 1'b0;
      loop_gain_o <= GAIN_RST;
      damping_ratio_setting_o <= DAMP_RST;
      loop_cfg_reg <= 16'h0000;
      fsw_o <= FSW_RST;
    end
    else if (link.cmd_wr)
    begin
      if (link.cmd_code == CMD_OPERATION)
        op_on_reg <= link.cmd_wdata[OP_ON_BIT];
      else if (link.cmd_code == CMD_ONOFF_CFG)
        onoff_reg <= link.cmd_wdata;
      else if (link.cmd_code == CMD_GAIN)
        loop_gain_o <= link.cmd_wdata;
      else if (link.cmd_code == CMD_DAMPING)
        damping_ratio_setting_o <= link.cmd_wdata;
      else if (link.cmd_code == CMD_LOOP_CFG)
        loop_cfg_reg <= link.cmd_wdata;
      else if (link.cmd_code == CMD_FSW)
        fsw_o <= link.cmd_wdata;
    end

  assign neg_duty_o = loop_cfg_reg[LOOP_NEG_BIT];

  // Policy word; the store request clears itself once honoured
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
      policy_reg <= POLICY_RST;
    else if (link.cmd_wr && link.cmd_code == CMD_POLICY)
      policy_reg <= link.cmd_wdata;
    else if (state_reg == ST_CAL && meas_done_i)
      policy_reg[POL_STORE_BIT] <= 1'b0;

  // Sequencer
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF:
        if (enable)
          state_next = ST_RAMP;
      ST_RAMP:
        if (!enable)
          state_next = ST_OFF;
        else if (ramp_done_i)
          state_next = cal_after_ramp ? ST_CAL : ST_RUN;
      ST_CAL:
        if (!enable)
          state_next = ST_OFF;
        else if (meas_done_i)
          state_next = ST_RUN;
      ST_RUN:
        if (!enable)
          state_next = ST_OFF;
        else if (policy_reg[POL_CONT_BIT] && ivl_cnt_reg == '0)
          state_next = ST_CAL;
      default:
        state_next = ST_OFF;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
      state_reg <= ST_OFF;
    else
      state_reg <= state_next;

  // Repeat interval for continuous calibration
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
      ivl_cnt_reg <= '0;
    else if (state_reg != ST_RUN)
      ivl_cnt_reg <= IVL_W'(CAL_IVL_CYC - 1);
    else if (ivl_cnt_reg != '0)
      ivl_cnt_reg <= ivl_cnt_reg - 1'b1;

  // Calibration bookkeeping
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
    begin
      first_done_reg <= 1'b0;
      cal_ok_reg <= 1'b0;
      store_all_o <= 1'b0;
    end
    else
    begin
      store_all_o <= 1'b0;
      if (state_reg == ST_CAL && meas_done_i)
      begin
        first_done_reg <= 1'b1;
        cal_ok_reg <= 1'b1;
        store_all_o <= policy_reg[POL_STORE_BIT];
      end
      else if (state_reg == ST_OFF && state_next == ST_RAMP)
        cal_ok_reg <= 1'b0;
    end

  // Resonance model word
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
      output_resonance_freq_o <= MODEL_RST;
    else if (state_reg != ST_OFF && state_next == ST_OFF)
      output_resonance_freq_o <= nvm_freq_i;
    else if (state_reg == ST_CAL && meas_done_i)
      output_resonance_freq_o <= meas_freq_i;
    else if (wr_model)
      output_resonance_freq_o <= link.cmd_wdata;

  // Outputs to the regulation law
  assign output_enable_o = state_reg != ST_OFF;
  assign low_bw_o = state_reg == ST_RAMP;
  assign inject_o = state_reg == ST_CAL;
  // Poles follow fsw_o, output_resonance_freq_o and setpoint_mv_o
  assign link.out_en = output_enable_o;
  assign link.good_out = 1'b0;
  assign link.good_oe = !(state_reg == ST_RUN && out_above_90_i
                          && (cal_ok_reg || !cal_after_ramp));

  // Read data one cycle after the read strobe
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
      rdata_reg <= 16'h0000;
    else if (link.cmd_rd)
    begin
      if (link.cmd_code == CMD_OPERATION)
        rdata_reg <= 16'(op_on_reg) << OP_ON_BIT;
      else if (link.cmd_code == CMD_ONOFF_CFG)
        rdata_reg <= onoff_reg;
      else if (link.cmd_code == CMD_MODEL)
        rdata_reg <= output_resonance_freq_o;
      else if (link.cmd_code == CMD_POLICY)
        rdata_reg <= policy_reg;
      else if (link.cmd_code == CMD_GAIN)
        rdata_reg <= loop_gain_o;
      else if (link.cmd_code == CMD_DAMPING)
        rdata_reg <= damping_ratio_setting_o;
      else if (link.cmd_code == CMD_LOOP_CFG)
        rdata_reg <= loop_cfg_reg;
      else if (link.cmd_code == CMD_FSW)
        rdata_reg <= fsw_o;
      else if (link.cmd_code == CMD_STATUS)
        rdata_reg <= {4'h0, strap_idx, 2'b00, cal_ok_reg, strap_open,
                      track_o, !link.good_oe, inject_o, output_enable_o};
      else if (link.cmd_code == CMD_SETPOINT)
        rdata_reg <= {3'b000, setpoint_mv_o};
      else
        rdata_reg <= 16'h0000;
    end

  assign link.cmd_rdata = rdata_reg;
endmodule : lco_device

// [verilog/lco_host.sv]
// Host end: register port to link commands, on/off switch, model replay
`timescale 1ns/1ps
module lco_host
  import lco_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Link to device
  lco_link_if.host link,
  // Software port
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // External sync source status
  input wire logic sync_stable_i
);
  logic [1:0] switch_reg;
  logic [15:0] shadow_reg;
  logic shadow_ok_reg;
  logic pend_reg;
  logic out_en_d_reg;
  logic own_sel_reg;
  logic [15:0] own_rdata_reg;
  logic own_addr;
  logic fwd_wr;
  logic send;
  logic release_pin;

  assign own_addr = addr_i == HOST_SWITCH;
  assign fwd_wr = wr_i && !own_addr
               && !(addr_i == CMD_MODEL && link.out_en);
  assign send = pend_reg && !link.out_en && !wr_i && !rd_i;

  assign link.cmd_wr = fwd_wr || send;
  assign link.cmd_rd = rd_i && !own_addr;
  assign link.cmd_code = send ? CMD_MODEL : addr_i;
  assign link.cmd_wdata = send ? shadow_reg : wdata_i;

  // Pin is released when switch bit 0 is set; with bit 1 also set, only once an external sync clock is stable
  assign release_pin = switch_reg[0]
                    && (!switch_reg[1] || sync_stable_i);
  assign link.ctrl_out = 1'b0;
  assign link.ctrl_oe = !release_pin;

  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
      switch_reg <= 2'b00;
    else if (wr_i && own_addr)
      switch_reg <= wdata_i[1:0];

  // Volatile model value kept for replay while disabled
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
    begin
      shadow_reg <= MODEL_RST;
      shadow_ok_reg <= 1'b0;
    end
    else if (wr_i && addr_i == CMD_MODEL)
    begin
      shadow_reg <= wdata_i;
      shadow_ok_reg <= 1'b1;
    end
    else if (wr_i && addr_i == CMD_FSW)
    begin
      shadow_reg <= wdata_i >> FLC_DIV_SHIFT;
      shadow_ok_reg <= 1'b1;
    end

  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
    begin
      pend_reg <= 1'b0;
      out_en_d_reg <= 1'b0;
    end
    else
    begin
      out_en_d_reg <= link.out_en;
      if ((wr_i && addr_i == CMD_MODEL && link.out_en)
          || (wr_i && addr_i == CMD_FSW)
          || (out_en_d_reg && !link.out_en && shadow_ok_reg))
        pend_reg <= 1'b1;
      else if (send)
        pend_reg <= 1'b0;
    end

  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
    begin
      own_sel_reg <= 1'b0;
      own_rdata_reg <= 16'h0000;
    end
    else
    begin
      own_sel_reg <= rd_i && own_addr;
      own_rdata_reg <= {11'h000, pend_reg, link.good_level, link.out_en,
                        switch_reg};
    end

  assign rdata_o = own_sel_reg ? own_rdata_reg : link.cmd_rdata;
endmodule : lco_host

// [tb/lco_link_checker.sv]
// Checker: link relations between the host and device ends
`timescale 1ns/1ps
module lco_link_checker
  import lco_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Link signals
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [3:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic [15:0] cmd_rdata,
  input wire logic ctrl_level,
  input wire logic good_level,
  input wire logic out_en
);
  logic [15:0] onoff_reg;
  logic [15:0] pol_reg;
  logic pin_only;
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  // Shadows of configuration words written over the link
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      onoff_reg <= ONOFF_RST;
    else if (cmd_wr && cmd_code == CMD_ONOFF_CFG)
      onoff_reg <= cmd_wdata;
  end
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      pol_reg <= POLICY_RST;
    else if (cmd_wr && cmd_code == CMD_POLICY)
      pol_reg <= cmd_wdata;
  end
  assign pin_only = onoff_reg[ONOFF_PIN_BIT] && !onoff_reg[ONOFF_CMD_BIT];
  a_model_when_off: assert property (
    cmd_wr && cmd_code == CMD_MODEL |-> !out_en)
    else $error("model word written while output enabled");
  a_pin_on_delay: assert property (
    $rose(out_en) && pin_only |->
    $past(ctrl_level, 3) == onoff_reg[ONOFF_POS_BIT])
    else $error("output enabled without synchronised pin");
  a_pin_off_delay: assert property (
    $fell(out_en) && pin_only |->
    $past(ctrl_level, 3) != onoff_reg[ONOFF_POS_BIT])
    else $error("output disabled against pin level");
  a_good_needs_en: assert property (
    good_level |-> out_en || $past(out_en))
    else $error("output good while output off");
  a_good_not_early: assert property (
    $rose(out_en) |-> !good_level)
    else $error("output good at start of ramp");
  a_status_enable: assert property (
    cmd_rd && cmd_code == CMD_STATUS |=> cmd_rdata[0] == $past(out_en))
    else $error("status enable bit wrong");
  a_onoff_readback: assert property (
    cmd_rd && cmd_code == CMD_ONOFF_CFG |=> cmd_rdata == $past(onoff_reg))
    else $error("on/off configuration readback wrong");
  a_cont_bit_read: assert property (
    cmd_rd && cmd_code == CMD_POLICY |=>
    cmd_rdata[POL_CONT_BIT] == $past(pol_reg[POL_CONT_BIT]))
    else $error("continuous calibration bit readback wrong");
endmodule : lco_link_checker

// [tb/lco_tb_top.sv]
// Testbench: host and device joined, driven through the software port
`timescale 1ns/1ps
module lco_tb_top;
  import lco_pkg::*;
  logic ref_clk_i, rst_i, wr_i, rd_i, strap_open_i, ramp_done_i;
  logic meas_done_i, out_above_90_i, sync_stable_i, hit;
  logic en_o, low_bw_o, inject_o, store_all_o, neg_duty_o, track_o;
  logic [3:0] addr_i;
  logic [12:0] strap_code_i, setpoint_mv_o, vmax_mv_o;
  logic [15:0] wdata_i, rdata_o, nvm_freq_i, meas_freq_i, model_o, exp_m;
  logic [15:0] fsw_o, gain_o, damp_o, m;
  int mismatches, n_checks, i, j;
  logic [3:0] rc [7] = '{CMD_POLICY, CMD_ONOFF_CFG, CMD_GAIN, CMD_DAMPING,
    CMD_FSW, CMD_MODEL, 4'hA};
  logic [15:0] rv [7] = '{16'h024B, 16'h0003, 16'h0080, 16'h0180,
    16'h0258, 16'h0012, 16'h0000};
  lco_link_if lnk();
  lco_device #(.CAL_IVL_CYC(20)) lco_device_i (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(lnk),
    .strap_code_i(strap_code_i), .strap_open_i(strap_open_i),
    .nvm_freq_i(nvm_freq_i), .ramp_done_i(ramp_done_i),
    .out_above_90_i(out_above_90_i), .meas_done_i(meas_done_i),
    .meas_freq_i(meas_freq_i), .output_enable_o(en_o),
    .low_bw_o(low_bw_o), .inject_o(inject_o), .store_all_o(store_all_o),
    .output_resonance_freq_o(model_o), .fsw_o(fsw_o),
    .loop_gain_o(gain_o), .damping_ratio_setting_o(damp_o),
    .neg_duty_o(neg_duty_o), .setpoint_mv_o(setpoint_mv_o),
    .vmax_mv_o(vmax_mv_o), .track_o(track_o));
  lco_host lco_host_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(lnk),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .sync_stable_i(sync_stable_i));
  lco_link_checker lco_link_checker_i (.ref_clk_i(ref_clk_i),
    .rst_i(rst_i), .cmd_wr(lnk.cmd_wr), .cmd_rd(lnk.cmd_rd),
    .cmd_code(lnk.cmd_code), .cmd_wdata(lnk.cmd_wdata),
    .cmd_rdata(lnk.cmd_rdata), .ctrl_level(lnk.ctrl_level),
    .good_level(lnk.good_level), .out_en(lnk.out_en));
  initial
  begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr
  task rd(input logic [3:0] a, input logic [15:0] k, input logic [15:0] e);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    chk("read data", e, rdata_o & k);
  endtask : rd
  // Selects: 0 enable, 1 inject, 2 good, 3 store, 5 model match
  function automatic logic pick(input int s);
    case (s)
      0: return en_o;
      1: return inject_o;
      2: return lnk.good_level;
      3: return store_all_o;
      default: return model_o === exp_m;
    endcase
  endfunction : pick
  task wait_for(input int s, input logic v, input string n);
    for (i = 0; i < 80 && pick(s) !== v; i++)
      @(posedge ref_clk_i) #1;
    chk(n, {15'h0, v}, {15'h0, pick(s)});
  endtask : wait_for
  task pulse(input logic meas);
    @(posedge ref_clk_i);
    ramp_done_i <= !meas;
    meas_done_i <= meas;
    @(posedge ref_clk_i);
    ramp_done_i <= 1'b0;
    meas_done_i <= 1'b0;
    #1;
  endtask : pulse
  task power_up(input logic [12:0] c, input logic o);
    @(posedge ref_clk_i);
    strap_code_i <= c;
    strap_open_i <= o;
    rst_i <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask : power_up
  task on_ramp(input logic [15:0] pol);
    wr(CMD_POLICY, pol);
    wr(HOST_SWITCH, 16'h0001);
    wait_for(0, 1'b1, "enable");
    pulse(1'b0);
  endtask : on_ramp
  task off();
    wr(HOST_SWITCH, 16'h0000);
    wait_for(0, 1'b0, "disable");
  endtask : off
  task summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize
  initial
  begin
    #300000;
    mismatches++;
    $display("[ERR] watchdog exp done got timeout");
    summarize();
  end
  initial
  begin
    {rst_i, wr_i, rd_i, ramp_done_i, meas_done_i} = 5'h01 << 4;
    {out_above_90_i, sync_stable_i, strap_open_i} = 3'h0;
    {addr_i, wdata_i, strap_code_i} = '0;
    {nvm_freq_i, meas_freq_i, exp_m} = {16'h0021, 16'h0040, 16'h0000};
    power_up(13'h1A6, 1'b0);
    chk("track", 16'h0001, {15'h0, track_o});
    chk("track setpoint", 16'h0000, {3'h0, setpoint_mv_o});
    power_up(13'h339, 1'b1);
    chk("open setpoint", 16'h0000, {3'h0, setpoint_mv_o});
    power_up(13'h339, 1'b0);
    chk("setpoint", 16'h0320, {3'h0, setpoint_mv_o});
    chk("vmax", 16'h0320, {3'h0, vmax_mv_o});
    @(posedge ref_clk_i);
    strap_code_i <= 13'h170C;
    rd(CMD_SETPOINT, 16'h1FFF, 16'h0320);
    rd(CMD_STATUS, 16'h0F00, 16'h0300);
    for (j = 0; j < 7; j++)
      rd(rc[j], 16'hFFFF, rv[j]);
    $display("test strap and reset done");
    wr(HOST_SWITCH, 16'h0003);
    rd(HOST_SWITCH, 16'h000F, 16'h0003);
    repeat (10) @(posedge ref_clk_i);
    #1;
    chk("held for sync", 16'h0000, {15'h0, en_o});
    @(posedge ref_clk_i);
    sync_stable_i <= 1'b1;
    wait_for(0, 1'b1, "enable");
    chk("low bw", 16'h0001, {15'h0, low_bw_o});
    pulse(1'b0);
    wait_for(1, 1'b1, "inject");
    pulse(1'b1);
    wait_for(1, 1'b0, "inject end");
    chk("model", 16'h0040, model_o);
    rd(CMD_MODEL, 16'hFFFF, 16'h0040);
    chk("good low", 16'h0000, {15'h0, lnk.good_level});
    @(posedge ref_clk_i);
    out_above_90_i <= 1'b1;
    wait_for(2, 1'b1, "good");
    rd(CMD_STATUS, 16'h0001, 16'h0001);
    off();
    chk("nvm revert", 16'h0021, model_o);
    meas_freq_i = 16'h0050;
    on_ramp(16'h024F);
    wait_for(1, 1'b1, "inject");
    pulse(1'b1);
    wait_for(3, 1'b1, "store");
    rd(CMD_POLICY, 16'hFFFF, 16'h024B);
    off();
    $display("test calibration done");
    m = model_o;
    on_ramp(16'h004B);
    wait_for(2, 1'b1, "good no cal");
    chk("no inject", 16'h0000, {15'h0, inject_o});
    chk("model kept", m, model_o);
    off();
    on_ramp(16'h124B);
    wait_for(2, 1'b1, "good first only");
    chk("no inject", 16'h0000, {15'h0, inject_o});
    off();
    power_up(13'h339, 1'b0);
    on_ramp(16'h124B);
    wait_for(1, 1'b1, "first cal");
    pulse(1'b1);
    off();
    $display("test policies done");
    meas_freq_i = 16'h0060;
    on_ramp(16'h034B);
    for (j = 0; j < 2; j++)
    begin
      wait_for(1, 1'b1, "repeat cal");
      pulse(1'b1);
      wait_for(1, 1'b0, "inject end");
    end
    wr(CMD_POLICY, 16'h024B);
    hit = 1'b0;
    repeat (40)
    begin
      @(posedge ref_clk_i);
      #1;
      hit = hit | inject_o;
    end
    chk("stopped", 16'h0000, {15'h0, hit});
    wr(CMD_MODEL, 16'h0077);
    chk("model held", 16'h0060, model_o);
    off();
    exp_m = 16'h0077;
    wait_for(5, 1'b1, "model replay");
    $display("test continuous done");
    wr(CMD_ONOFF_CFG, 16'h0002);
    wait_for(0, 1'b1, "negative on");
    wr(CMD_OPERATION, 16'h0000);
    wr(CMD_ONOFF_CFG, 16'h0004);
    wait_for(0, 1'b0, "command off");
    wr(CMD_OPERATION, 16'h0080);
    wait_for(0, 1'b1, "command on");
    rd(CMD_ONOFF_CFG, 16'hFFFF, 16'h0004);
    wr(CMD_ONOFF_CFG, 16'h0000);
    wr(CMD_OPERATION, 16'h0000);
    wait_for(0, 1'b1, "always on");
    wr(CMD_ONOFF_CFG, 16'h0003);
    wait_for(0, 1'b0, "pin low off");
    wr(CMD_GAIN, 16'h00CC);
    chk("gain", 16'h00CC, gain_o);
    wr(CMD_DAMPING, 16'h0100);
    chk("damping", 16'h0100, damp_o);
    wr(CMD_LOOP_CFG, 16'h0001);
    chk("neg duty", 16'h0001, {15'h0, neg_duty_o});
    wr(CMD_FSW, 16'h0320);
    chk("fsw", 16'h0320, fsw_o);
    exp_m = 16'h0019;
    wait_for(5, 1'b1, "model fsw div");
    $display("test enable sources done");
    summarize();
  end
endmodule : lco_tb_top
